// file: verilog/serial_core_pkg.sv
// Constants shared by the universal serial shift core
// Behaviour
// - One 8-bit shift register, CPU readable/writable
// - Register MSB drives pin chosen by wire mode
// - Output latch changes on opposite external clock edge
// - Input bits always sampled from data pin
// - 4-bit transfer counter, CPU readable/writable
// - Counter overflow sets interrupt-capable flag
// - Shift register and counter share clock source
// - External clock counts both edges
// - Clock from pin, timer match or strobe
// - Two-wire start condition detected, may interrupt
// - Hold clock low after start or overflow in two-wire mode
// - Two- and three-wire, master or slave
// - Interrupts wake idle; start wakes all
// - Edge mode zero samples rising, shifts falling
// - Three-wire byte ends after sixteen edges
// - No hardware slave select in three-wire
`default_nettype none
package serial_core_pkg;
	localparam int DATA_W = 8;
	localparam int CNT_W = 4;
	localparam int SYNC_W = 3;
	// Wire mode codes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_THREE = 2'h1;
	localparam logic [1:0] MODE_TWO = 2'h2;
	// Clock source codes
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_TIMER = 2'h1;
	localparam logic [1:0] SRC_SOFT = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;
	// Reset values, counter step and last count
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] CNT_LAST = 4'hf;
	// Sync vector bit positions
	localparam int POS_RISE = 0;
	localparam int POS_FALL = 1;
	localparam int POS_DIN = 2;
endpackage
`default_nettype wire

// file: verilog/universal_serial_core.sv
// Universal serial shift core: shift register, edge counter, two-wire control
`timescale 1ns/1ps
`default_nettype none
module universal_serial_core #(
	parameter int DATA_W = serial_core_pkg::DATA_W,
	parameter int CNT_W = serial_core_pkg::CNT_W
) (
	// System
	input wire logic clk,
	input wire logic rstn,
	// Shift data access
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	output logic [7:0] shift_data_register,
	// Counter and flag access
	input wire logic cnt_wr,
	input wire logic [3:0] cnt_wdata,
	output logic [3:0] counter_value,
	input wire logic ovf_clr,
	output logic counter_overflow_flag,
	input wire logic start_clr,
	output logic start_flag,
	// Configuration
	input wire logic [1:0] wire_mode,
	input wire logic [1:0] clock_source_sel,
	input wire logic external_clock_edge_select,
	input wire logic ovf_irq_en,
	input wire logic start_irq_en,
	input wire logic start_hold_en,
	input wire logic ovf_hold_en,
	// Internal clock sources
	input wire logic timer_match,
	input wire logic sw_strobe,
	// Link pins
	input wire logic serial_clock_pin,
	input wire logic serial_data_in_pin,
	output logic data_out_pin,
	output logic sda_out,
	output logic sda_oe_n,
	output logic scl_out,
	output logic scl_oe_n,
	// Interrupt and wake requests
	output logic ovf_irq,
	output logic start_irq,
	output logic wake_idle,
	output logic wake_any
);
	// Fixed widths: the pin and latch logic assume one byte per transfer
	if (DATA_W != 8 || CNT_W != 4) begin : g_bad_size
		$error("Core supports only 8-bit data and 4-bit counter");
	end

	// Link domain: capture data and flag each edge by a toggle
	logic rise_tog_reg, rise_bit_reg, fall_tog_reg, fall_bit_reg;

	always_ff @(posedge serial_clock_pin or negedge rstn) begin
		if (!rstn) begin
			rise_tog_reg <= 1'b0;
			rise_bit_reg <= 1'b0;
		end else begin
			rise_tog_reg <= ~rise_tog_reg;
			rise_bit_reg <= serial_data_in_pin;
		end
	end

	always_ff @(negedge serial_clock_pin or negedge rstn) begin
		if (!rstn) begin
			fall_tog_reg <= 1'b0;
			fall_bit_reg <= 1'b0;
		end else begin
			fall_tog_reg <= ~fall_tog_reg;
			fall_bit_reg <= serial_data_in_pin;
		end
	end

	// Three-stage synchronisers; a change counts once stages two and three agree
	logic [2:0] async_in, s1_reg, s2_reg, s3_reg, filt_reg;
	logic [2:0] ev, filt_next;
	assign async_in = {serial_data_in_pin, fall_tog_reg, rise_tog_reg};
	assign ev = ~(s2_reg ^ s3_reg) & (s3_reg ^ filt_reg);
	assign filt_next = filt_reg ^ ev;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
			s3_reg <= 3'h0;
			filt_reg <= 3'h0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	// Edge events and decoded modes
	wire rise_ev = ev[serial_core_pkg::POS_RISE];
	wire fall_ev = ev[serial_core_pkg::POS_FALL];
	wire din_level = filt_next[serial_core_pkg::POS_DIN];
	wire din_fall = ev[serial_core_pkg::POS_DIN] & ~din_level;
	// Toggles differ while the clock pin is high
	wire scl_high = filt_next[serial_core_pkg::POS_RISE]
		^ filt_next[serial_core_pkg::POS_FALL];
	wire three_wire = wire_mode == serial_core_pkg::MODE_THREE;
	wire two_wire = wire_mode == serial_core_pkg::MODE_TWO;
	wire ext = clock_source_sel == serial_core_pkg::SRC_EXT;
	// Timer match or software strobe as the shift clock
	wire int_ev = (clock_source_sel == serial_core_pkg::SRC_TIMER
		&& timer_match)
		|| (clock_source_sel == serial_core_pkg::SRC_SOFT && sw_strobe);
	// Mode zero samples on rise, mode one on fall
	wire ext_sample = external_clock_edge_select ? fall_ev : rise_ev;
	wire ext_shift = external_clock_edge_select ? rise_ev : fall_ev;
	wire ext_bit = external_clock_edge_select ? fall_bit_reg : rise_bit_reg;
	wire sample_ev = ext ? ext_sample : int_ev;
	wire shift_out_ev = ext ? ext_shift : int_ev;
	// Both edges counted under the external clock
	wire count_ev = ext ? (rise_ev | fall_ev) : int_ev;
	// Input always from the data pin
	wire sample_bit = ext ? ext_bit : din_level;

	// Shift register, output latch, counter and flags
	logic [7:0] sr_reg, sr_next;
	logic [3:0] cnt_reg, cnt_next;
	logic out_reg, out_next;
	logic ovf_reg, ovf_next, start_reg, start_next, hold_next;
	// Sixteen external edges make one byte and wrap
	// A counter write suppresses the wrap, so software can rearm safely
	wire cnt_wrap = count_ev && !cnt_wr && cnt_reg == serial_core_pkg::CNT_LAST;
	wire start_det = two_wire && din_fall && scl_high;

	// CPU write wins over a shift in the same cycle
	assign sr_next = data_wr ? data_wdata
		: sample_ev ? {sr_reg[6:0], sample_bit} : sr_reg;
	// Latch follows the MSB on the output edge or on a CPU write
	assign out_next = data_wr ? data_wdata[7]
		: shift_out_ev ? sr_next[7] : out_reg;
	// CPU-writable counter
	// Counter steps with the shift clock and wraps
	assign cnt_next = cnt_wr ? cnt_wdata
		: count_ev ? 4'(cnt_reg + serial_core_pkg::CNT_ONE) : cnt_reg;
	// Set wins over the write-one clear
	assign ovf_next = cnt_wrap | (ovf_reg & ~ovf_clr);
	// Start condition: data falls while clock is high
	assign start_next = start_det | (start_reg & ~start_clr);
	// Clock held low until software clears the cause
	assign hold_next = two_wire && ((start_next && start_hold_en)
		|| (ovf_next && ovf_hold_en));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sr_reg <= serial_core_pkg::DATA_RST;
			cnt_reg <= serial_core_pkg::CNT_RST;
			out_reg <= 1'b0;
			ovf_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			sr_reg <= sr_next;
			cnt_reg <= cnt_next;
			out_reg <= out_next;
			ovf_reg <= ovf_next;
			start_reg <= start_next;
		end
	end

	// Registered outputs; pin roles follow the wire mode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift_data_register <= serial_core_pkg::DATA_RST;
			counter_value <= serial_core_pkg::CNT_RST;
			counter_overflow_flag <= 1'b0;
			start_flag <= 1'b0;
			data_out_pin <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
			scl_out <= 1'b0;
			scl_oe_n <= 1'b1;
		end else begin
			shift_data_register <= sr_next;
			counter_value <= cnt_next;
			counter_overflow_flag <= ovf_next;
			start_flag <= start_next;
			// No slave select; software gates the driver
			data_out_pin <= three_wire & out_next;
			sda_out <= 1'b0;
			// Open drain: pull low only for a zero bit
			sda_oe_n <= ~(two_wire & ~out_next);
			scl_out <= 1'b0;
			scl_oe_n <= ~hold_next;
		end
	end

	// Interrupt and wake requests
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ovf_irq <= 1'b0;
			start_irq <= 1'b0;
			wake_idle <= 1'b0;
			wake_any <= 1'b0;
		end else begin
			ovf_irq <= ovf_next & ovf_irq_en;
			start_irq <= start_next & start_irq_en;
			wake_idle <= (ovf_next & ovf_irq_en) | (start_next & start_irq_en);
			// Only the start detector can wake from deep sleep
			wake_any <= two_wire & start_next & start_irq_en;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_wrap_sets_flag: assert property (cnt_wrap |=> counter_overflow_flag
		&& counter_value == serial_core_pkg::CNT_RST)
		else $error("overflow did not set flag and wrap counter");
	a_flag_sticky: assert property (ovf_reg && !ovf_clr |=> ovf_reg)
		else $error("overflow flag dropped without clear");
	a_data_write: assert property (data_wr |=>
		shift_data_register == $past(data_wdata))
		else $error("shift register missed a CPU write");
	a_cnt_write: assert property (cnt_wr |=>
		counter_value == $past(cnt_wdata))
		else $error("counter missed a CPU write");
	a_shift_counts: assert property (sample_ev && !ext && !data_wr
		&& !cnt_wr |=> counter_value == 4'($past(cnt_reg) + 4'h1)
		&& sr_reg[0] == $past(sample_bit))
		else $error("shift and count not together");
	a_edges_counted: assert property (ext && (rise_ev ^ fall_ev)
		&& !cnt_wr |=> cnt_reg == 4'($past(cnt_reg) + 4'h1))
		else $error("external edge not counted");
	a_input_sampled: assert property (sample_ev && !data_wr |=>
		sr_reg[0] == $past(sample_bit))
		else $error("sampled bit not shifted in");
	a_latch_holds: assert property (ext && sample_ev && !shift_out_ev
		&& !data_wr |=> $stable(out_reg))
		else $error("output changed on sampling edge");
	a_start_detect: assert property (start_det |=> start_flag
		##1 (start_flag || $past(start_clr)))
		else $error("start condition not flagged");
	a_hold_low: assert property (two_wire && start_reg && start_hold_en
		&& !start_clr |=> !scl_oe_n)
		else $error("clock not held after start");
	a_three_no_sda: assert property (three_wire |=> sda_oe_n
		&& scl_oe_n)
		else $error("open-drain pins driven in three-wire mode");
	a_wake_deep: assert property (wake_any |-> start_flag)
		else $error("deep wake without start condition");

	// Interrupt requests rise in the same cycle as the flags
	a_ovf_irq: assert property (ovf_next && ovf_irq_en |=>
		ovf_irq && wake_idle)
		else $error("overflow did not raise interrupt and wake");

	// A counter write never raises the overflow flag by itself
	a_write_no_ovf: assert property (cnt_wr && !ovf_reg |=>
		!ovf_reg)
		else $error("overflow set by a counter write");

	// Bit seven reaches the three-wire data pin on a CPU write
	a_msb_to_pin: assert property (three_wire && data_wr |=>
		data_out_pin == $past(data_wdata[7]))
		else $error("data pin does not show the written MSB");

	// Open-drain data line pulls low only for a zero bit
	a_sda_zero: assert property (two_wire && !out_next |=>
		!sda_oe_n)
		else $error("two-wire data line not pulled for a zero");

	// Wait state after overflow until software clears the flag
	a_ovf_hold: assert property (two_wire && ovf_reg && ovf_hold_en
		&& !ovf_clr |=> !scl_oe_n)
		else $error("clock not held after overflow");

	// Start detection only exists on the two-wire bus
	a_start_two: assert property (!two_wire && !start_reg
		|=> !start_reg)
		else $error("start flagged outside two-wire mode");

	// Pulses of the unselected source must not clock anything
	a_src_refused: assert property (clock_source_sel
		== serial_core_pkg::SRC_SOFT && timer_match && !sw_strobe
		&& !cnt_wr |=> $stable(counter_value))
		else $error("unselected clock source moved the counter");

	// Deep wake needs two-wire mode as well as the start flag
	a_deep_mode: assert property (wake_any |-> $past(two_wire))
		else $error("deep wake outside two-wire mode");

	c_byte_done: cover property (ext && three_wire && cnt_wrap);
	c_start_seen: cover property (start_det ##[1:200] start_clr);
	c_ovf_hold: cover property (two_wire && ovf_hold_en && cnt_wrap);
	c_mode_one: cover property (ext && external_clock_edge_select
		&& sample_ev);
	c_soft_byte: cover property (!ext && int_ev && cnt_wrap);
endmodule
`default_nettype wire

// file: verif/serial_link_partner.sv
// Link-side master model driving the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module serial_link_partner (
	// Pins towards the core
	output logic scl,
	output logic sda,
	input wire logic data_in,
	// Byte seen from the core
	output logic [7:0] got
);
	logic lk = 1'b0;
	initial begin
		scl = 1'b0;
		sda = 1'b1;
		got = 8'h00;
		#5;
		forever #32 lk = ~lk;
	end
	task automatic set_data(input logic b);
		sda = b;
	endtask
	// Levels last two link periods, so core edges never merge
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge lk) sda = b[i];
			repeat (2) @(posedge lk);
			got = {got[6:0], data_in};
			scl = 1'b1;
			repeat (2) @(posedge lk);
			scl = 1'b0;
		end
		// Released line shows the inverse, never the last bit
		repeat (2) @(posedge lk);
		sda = ~sda;
	endtask
	task automatic start_cond();
		scl = 1'b1;
		sda = 1'b1;
		repeat (4) @(posedge lk);
		sda = 1'b0;
		repeat (4) @(posedge lk);
	endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the universal serial shift core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {
		logic [7:0] d;
		logic din;
		int n;
		logic [1:0] src;
		logic tmr;
		logic [7:0] sr;
		logic [3:0] cnt;
	} row_t;
	row_t rows[4] = '{
		'{8'ha5, 1'b1, 1, serial_core_pkg::SRC_SOFT, 1'b0, 8'h4b, 4'h1},
		'{8'ha5, 1'b0, 3, serial_core_pkg::SRC_TIMER, 1'b1, 8'h28, 4'h3},
		'{8'h81, 1'b1, 8, serial_core_pkg::SRC_SOFT, 1'b0, 8'hff, 4'h8},
		'{8'h3c, 1'b0, 2, serial_core_pkg::SRC_SOFT, 1'b1, 8'h3c, 4'h0}};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic data_wr = 1'b0, cnt_wr = 1'b0, ovf_clr = 1'b0, start_clr = 1'b0;
	logic [7:0] data_wdata = 8'h00;
	logic [3:0] cnt_wdata = 4'h0;
	logic [1:0] wire_mode = serial_core_pkg::MODE_THREE;
	logic [1:0] clock_source_sel = serial_core_pkg::SRC_NONE;
	logic external_clock_edge_select = 1'b0, ovf_irq_en = 1'b0;
	logic start_irq_en = 1'b0, start_hold_en = 1'b0, ovf_hold_en = 1'b0;
	logic timer_match = 1'b0, sw_strobe = 1'b0;
	logic [7:0] shift_data_register, got;
	logic [3:0] counter_value;
	logic counter_overflow_flag, start_flag, data_out_pin, sda_out, sda_oe_n;
	logic scl_out, scl_oe_n, ovf_irq, start_irq, wake_idle, wake_any;
	logic p_scl, p_sda, serial_clock_pin, serial_data_in_pin;
	int failures = 0, total_checks = 0, cycles = 0;
	// Open-drain wires: either party may pull low
	assign serial_clock_pin = p_scl & (scl_oe_n | scl_out);
	assign serial_data_in_pin = p_sda & (sda_oe_n | sda_out);
	universal_serial_core dut (.clk, .rstn, .data_wr, .data_wdata,
		.shift_data_register, .cnt_wr, .cnt_wdata, .counter_value, .ovf_clr,
		.counter_overflow_flag, .start_clr, .start_flag, .wire_mode,
		.clock_source_sel, .external_clock_edge_select, .ovf_irq_en,
		.start_irq_en, .start_hold_en, .ovf_hold_en, .timer_match, .sw_strobe,
		.serial_clock_pin, .serial_data_in_pin, .data_out_pin, .sda_out,
		.sda_oe_n, .scl_out, .scl_oe_n, .ovf_irq, .start_irq, .wake_idle,
		.wake_any);
	serial_link_partner link (.scl(p_scl), .sda(p_sda),
		.data_in(data_out_pin), .got(got));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle strobe on the named lines, then settle
	task automatic pulse(input logic d, input logic c, input logic o, input logic s);
		@(posedge clk);
		data_wr <= d;
		cnt_wr <= c;
		ovf_clr <= o;
		start_clr <= s;
		@(posedge clk);
		{data_wr, cnt_wr, ovf_clr, start_clr} <= 4'h0;
		tick(2);
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		tick(9);
		check(shift_data_register, 8'h00);
		check({counter_overflow_flag, scl_oe_n, sda_oe_n}, 8'h03);
		@(posedge clk) rstn <= 1'b1;
		foreach (rows[i]) begin
			link.set_data(rows[i].din);
			clock_source_sel <= rows[i].src;
			data_wdata <= rows[i].d;
			cnt_wdata <= 4'h0;
			pulse(1'b1, 1'b1, 1'b0, 1'b0);
			tick(6);
			repeat (rows[i].n) begin
				timer_match <= rows[i].tmr;
				sw_strobe <= !rows[i].tmr;
				@(posedge clk);
			end
			{timer_match, sw_strobe} <= 2'h0;
			tick(2);
			check(shift_data_register, rows[i].sr);
			check(counter_value, rows[i].cnt);
			check(data_out_pin, rows[i].sr[7]);
		end
		// Overflow from the top count with the clock hold armed
		wire_mode <= serial_core_pkg::MODE_TWO;
		{ovf_hold_en, ovf_irq_en} <= 2'h3;
		cnt_wdata <= serial_core_pkg::CNT_LAST;
		pulse(1'b0, 1'b1, 1'b0, 1'b0);
		@(posedge clk) sw_strobe <= 1'b1;
		@(posedge clk) sw_strobe <= 1'b0;
		tick(2);
		check(counter_value, 8'h0);
		check({counter_overflow_flag, ovf_irq, wake_idle}, 8'h7);
		check(scl_oe_n, 8'h0);
		pulse(1'b0, 1'b0, 1'b1, 1'b0);
		check({counter_overflow_flag, scl_oe_n}, 8'h1);
		// Whole byte clocked by the far side
		{wire_mode, clock_source_sel} <= 4'h7;
		ovf_hold_en <= 1'b0;
		data_wdata <= 8'ha5;
		cnt_wdata <= 4'h0;
		pulse(1'b1, 1'b1, 1'b0, 1'b0);
		link.send(8'h3c);
		tick(10);
		check(shift_data_register, 8'h3c);
		check({counter_overflow_flag, counter_value}, 8'h10);
		check(got, 8'ha5);
		// Start condition on the two-wire bus
		{wire_mode, clock_source_sel} <= 4'h8;
		{start_hold_en, start_irq_en} <= 2'h3;
		data_wdata <= 8'hff;
		pulse(1'b1, 1'b0, 1'b1, 1'b0);
		link.start_cond();
		tick(3);
		check({start_flag, start_irq, wake_any}, 8'h7);
		check(scl_oe_n, 8'h0);
		pulse(1'b0, 1'b0, 1'b0, 1'b1);
		check({start_flag, scl_oe_n}, 8'h1);
		conclude();
	end
endmodule
`default_nettype wire
